//--- pgr_pkg.sv
package pgr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] PGR_OFF_UNLOCK_KEY   = 8'h0b;
  localparam logic [7:0] PGR_OFF_GOOD_STATUS  = 8'h0c;
  localparam logic [7:0] PGR_OFF_GOOD_CONTROL = 8'h0d;
  localparam logic [7:0] PGR_OFF_BUCK_ONE     = 8'h0e;

  // ==========================================================
  // key values and reset values
  localparam logic [7:0] PGR_UNLOCK_CODE      = 8'h7d;
  localparam logic [7:0] PGR_KEY_RESET        = 8'h00;
  localparam logic [7:0] PGR_STATUS_RESET     = 8'h00;
  localparam logic [1:0] PGR_DELAY_RESET      = 2'h0;
  localparam logic       PGR_MASK_RESET       = 1'b1;
  localparam logic       PGR_EXT_ADJ_RESET    = 1'b0;
  localparam logic [5:0] PGR_VCODE_RESET      = 6'h00; // code 0 is the lowest level
  // bus address of the device, value arbitrary
  localparam logic [6:0] PGR_BUS_ADDR         = 7'h2a;

  // ==========================================================
  // field positions
  localparam int PGR_BIT_LIN1_MASK  = 3;
  localparam int PGR_BIT_LIN2_MASK  = 2;
  localparam int PGR_BIT_EXT_ADJ    = 7;
  localparam int PGR_ST_LIN3        = 6;
  localparam int PGR_ST_LIN4        = 5;
  localparam int PGR_ST_BUCK1       = 4;
  localparam int PGR_ST_BUCK2       = 3;
  localparam int PGR_ST_BUCK3       = 2;
  localparam int PGR_ST_LIN1        = 1;
  localparam int PGR_ST_LIN2        = 0;

  // ==========================================================
  // timing
  localparam longint PGR_CLK_HZ     = 200000000;
  localparam longint PGR_DLY0_MS    = 20;
  localparam longint PGR_DLY1_MS    = 100;
  localparam longint PGR_DLY2_MS    = 200;
  localparam longint PGR_DLY3_MS    = 400;
  localparam logic [31:0] PGR_DLY0_CYC = 32'(PGR_DLY0_MS * PGR_CLK_HZ / 1000);
  localparam logic [31:0] PGR_DLY1_CYC = 32'(PGR_DLY1_MS * PGR_CLK_HZ / 1000);
  localparam logic [31:0] PGR_DLY2_CYC = 32'(PGR_DLY2_MS * PGR_CLK_HZ / 1000);
  localparam logic [31:0] PGR_DLY3_CYC = 32'(PGR_DLY3_MS * PGR_CLK_HZ / 1000);

  // ==========================================================
  // serial slave states
  typedef enum logic [6:0] {
    PGR_IDLE    = 7'b0000001,
    PGR_ADDR    = 7'b0000010,
    PGR_ADDR_AK = 7'b0000100,
    PGR_WR      = 7'b0001000,
    PGR_WR_AK   = 7'b0010000,
    PGR_RD      = 7'b0100000,
    PGR_RD_AK   = 7'b1000000
  } pgr_state_t;

endpackage

//--- pgr_good_delay.sv
module pgr_good_delay
  import pgr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        all_good,
  input  wire logic [31:0] limit,
  output logic             good_out
);

  // ==========================================================
  // qualification counter
  logic [31:0] count;
  wire logic   reached = (count >= limit);

  // counter restarts whenever any watched status drops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count    <= 32'h0;
      good_out <= 1'b0;
    end else if (!all_good) begin
      count    <= 32'h0;
      good_out <= 1'b0;
    end else begin
      if (!reached) begin
        count <= count + 32'h1;
      end
      good_out <= reached;
    end
  end

endmodule

//--- pgr_regs.sv
module pgr_regs
  import pgr_pkg::*;
#(
  parameter logic [31:0] DLY0_CYC = PGR_DLY0_CYC,
  parameter logic [31:0] DLY1_CYC = PGR_DLY1_CYC,
  parameter logic [31:0] DLY2_CYC = PGR_DLY2_CYC,
  parameter logic [31:0] DLY3_CYC = PGR_DLY3_CYC
)
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       lin_reg_one_good,
  input  wire logic       lin_reg_two_good,
  input  wire logic       lin_reg_three_good,
  input  wire logic       lin_reg_four_good,
  input  wire logic       load_switch_one,
  input  wire logic       load_switch_two,
  input  wire logic       buck_one_good,
  input  wire logic       buck_two_good,
  input  wire logic       buck_three_good,
  output logic            rails_good_pin,
  output logic            buck_one_external_adjust,
  output logic [5:0]      buck_one_voltage_code
);

  // ==========================================================
  // registers
  logic [7:0] unlock_key_value;
  logic       key_live;      // key was written in the previous transaction
  logic       key_in_txn;    // key written in the current transaction
  logic [7:0] rail_good_status;
  logic       lin_reg_one_good_mask;
  logic       lin_reg_two_good_mask;
  logic [1:0] good_pin_delay_sel;

  // ==========================================================
  // serial slave state
  pgr_state_t state;
  logic       scl_q;
  logic       sda_q;
  logic [2:0] bit_cnt;
  logic       byte_full;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic       ptr_next_byte; // next written byte is the register pointer
  logic       master_nack;
  logic       txn_active;

  // ==========================================================
  // read decode, reserved bits come back as zero
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    case (addr)
      PGR_OFF_UNLOCK_KEY:   read_reg = unlock_key_value;
      PGR_OFF_GOOD_STATUS:  read_reg = rail_good_status;
      PGR_OFF_GOOD_CONTROL: read_reg = {4'h0, lin_reg_one_good_mask,
                                        lin_reg_two_good_mask, good_pin_delay_sel};
      PGR_OFF_BUCK_ONE:     read_reg = {buck_one_external_adjust, 1'b0,
                                        buck_one_voltage_code};
      default:              read_reg = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // bus edges, inputs already synchronous to core_clk
  wire logic scl_rise  = scl_in & ~scl_q;
  wire logic scl_fall  = ~scl_in & scl_q;
  wire logic bus_start = scl_in & scl_q & sda_q & ~sda_in;
  wire logic bus_stop  = scl_in & scl_q & ~sda_q & sda_in;
  wire logic txn_end   = (bus_start | bus_stop) & txn_active;
  wire logic addr_hit  = (shift[7:1] == PGR_BUS_ADDR);
  wire logic byte_done = scl_fall & byte_full;
  wire logic wr_fire   = byte_done & (state == PGR_WR) & ~ptr_next_byte;
  wire logic is_prot   = (ptr == PGR_OFF_GOOD_CONTROL) | (ptr == PGR_OFF_BUCK_ONE);
  wire logic unlocked  = key_live & (unlock_key_value == PGR_UNLOCK_CODE);
  wire logic prot_wr   = wr_fire & is_prot & unlocked;
  wire logic key_wr    = wr_fire & (ptr == PGR_OFF_UNLOCK_KEY);

  // open-drain data line: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = (state == PGR_ADDR_AK) | (state == PGR_WR_AK) |
                   ((state == PGR_RD) & ~tx[7]);

  // edge history for start, stop and clock edges
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // ==========================================================
  // serial slave: address, pointer, write data, read data
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state         <= PGR_IDLE;
      bit_cnt       <= 3'h0;
      byte_full     <= 1'b0;
      shift         <= 8'h00;
      tx            <= 8'h00;
      ptr           <= 8'h00;
      ptr_next_byte <= 1'b0;
      master_nack   <= 1'b0;
      txn_active    <= 1'b0;
    end else if (bus_start) begin
      state      <= PGR_ADDR;
      bit_cnt    <= 3'h0;
      byte_full  <= 1'b0;
      txn_active <= 1'b0;
    end else if (bus_stop) begin
      state      <= PGR_IDLE;
      txn_active <= 1'b0;
    end else begin
      case (state)
        PGR_ADDR, PGR_WR: begin
          if (scl_rise && !byte_full) begin
            shift     <= {shift[6:0], sda_in};
            bit_cnt   <= bit_cnt + 3'h1;
            byte_full <= (bit_cnt == 3'h7);
          end
          if (byte_done) begin
            byte_full <= 1'b0;
            if (state == PGR_ADDR) begin
              if (addr_hit) begin
                state         <= PGR_ADDR_AK;
                txn_active    <= 1'b1;
                ptr_next_byte <= ~shift[0];
                tx            <= read_reg(ptr);
              end else begin
                state <= PGR_IDLE; // not ours, wait for the next start
              end
            end else begin
              state         <= PGR_WR_AK;
              ptr_next_byte <= 1'b0;
              ptr           <= ptr_next_byte ? shift : ptr + 8'h01;
            end
          end
        end
        PGR_ADDR_AK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (shift[0]) begin
              state <= PGR_RD;
              ptr   <= ptr + 8'h01;
            end else begin
              state <= PGR_WR;
            end
          end
        end
        PGR_WR_AK: begin
          if (scl_fall) begin
            state   <= PGR_WR;
            bit_cnt <= 3'h0;
          end
        end
        PGR_RD: begin
          if (scl_fall) begin
            tx      <= {tx[6:0], 1'b0};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              state <= PGR_RD_AK;
            end
          end
        end
        PGR_RD_AK: begin
          if (scl_rise) begin
            master_nack <= sda_in;
          end
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (master_nack) begin
              state <= PGR_IDLE; // host is done, wait for stop
            end else begin
              state <= PGR_RD;
              tx    <= read_reg(ptr);
              ptr   <= ptr + 8'h01;
            end
          end
        end
        default: state <= PGR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // unlock key: lives for one transaction after it was written,
  // and a protected write uses it up so only one gets through
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      unlock_key_value <= PGR_KEY_RESET;
      key_live         <= 1'b0;
      key_in_txn       <= 1'b0;
    end else if (key_wr) begin
      unlock_key_value <= shift;
      key_in_txn       <= 1'b1;
      key_live         <= 1'b0;
    end else if (prot_wr) begin
      unlock_key_value <= PGR_KEY_RESET;
      key_live         <= 1'b0;
    end else if (txn_end) begin
      key_in_txn <= 1'b0;
      key_live   <= key_in_txn;
      if (!key_in_txn) begin
        unlock_key_value <= PGR_KEY_RESET;
      end
    end
  end

  // protected control registers, written only while unlocked
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lin_reg_one_good_mask    <= PGR_MASK_RESET;
      lin_reg_two_good_mask    <= PGR_MASK_RESET;
      good_pin_delay_sel       <= PGR_DELAY_RESET;
      buck_one_external_adjust <= PGR_EXT_ADJ_RESET;
      buck_one_voltage_code    <= PGR_VCODE_RESET;
    end else if (prot_wr && ptr == PGR_OFF_GOOD_CONTROL) begin
      lin_reg_one_good_mask <= shift[PGR_BIT_LIN1_MASK];
      lin_reg_two_good_mask <= shift[PGR_BIT_LIN2_MASK];
      good_pin_delay_sel    <= shift[1:0];
    end else if (prot_wr && ptr == PGR_OFF_BUCK_ONE) begin
      buck_one_external_adjust <= shift[PGR_BIT_EXT_ADJ];
      buck_one_voltage_code    <= shift[5:0];
    end
  end

  // ==========================================================
  // status sampling, bit 7 stays zero
  logic [7:0] next_status;
  always_comb begin
    next_status               = 8'h00;
    next_status[PGR_ST_LIN3]  = lin_reg_three_good | load_switch_one;
    next_status[PGR_ST_LIN4]  = lin_reg_four_good | load_switch_two;
    next_status[PGR_ST_BUCK1] = buck_one_good;
    next_status[PGR_ST_BUCK2] = buck_two_good;
    next_status[PGR_ST_BUCK3] = buck_three_good;
    next_status[PGR_ST_LIN1]  = lin_reg_one_good;
    next_status[PGR_ST_LIN2]  = lin_reg_two_good;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rail_good_status <= PGR_STATUS_RESET;
    end else begin
      rail_good_status <= next_status;
    end
  end

  // ==========================================================
  // good pin: masked statuses are forced good before the and
  wire logic all_good = rail_good_status[PGR_ST_LIN3] & rail_good_status[PGR_ST_LIN4] &
                        rail_good_status[PGR_ST_BUCK1] & rail_good_status[PGR_ST_BUCK2] &
                        rail_good_status[PGR_ST_BUCK3] &
                        (rail_good_status[PGR_ST_LIN1] | lin_reg_one_good_mask) &
                        (rail_good_status[PGR_ST_LIN2] | lin_reg_two_good_mask);
  wire logic [31:0] dly_limit = (good_pin_delay_sel == 2'h0) ? DLY0_CYC :
                                (good_pin_delay_sel == 2'h1) ? DLY1_CYC :
                                (good_pin_delay_sel == 2'h2) ? DLY2_CYC : DLY3_CYC;

  pgr_good_delay u_delay (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .all_good (all_good),
    .limit    (dly_limit),
    .good_out (rails_good_pin)
  );

endmodule

//--- pgr_regs_chk.sv
module pgr_regs_chk #(
  parameter logic [31:0] DLY0_CYC = 32'h00000014,
  parameter logic [31:0] DLY3_CYC = 32'h00000190
) (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       scl_in,
  input wire logic       lin_reg_one_good,
  input wire logic       lin_reg_two_good,
  input wire logic       lin_reg_three_good,
  input wire logic       lin_reg_four_good,
  input wire logic       load_switch_one,
  input wire logic       load_switch_two,
  input wire logic       buck_one_good,
  input wire logic       buck_two_good,
  input wire logic       buck_three_good,
  input wire logic       rails_good_pin,
  input wire logic       buck_one_external_adjust,
  input wire logic [5:0] buck_one_voltage_code
);
  timeunit 1ns;
  timeprecision 1ps;

  // ========================
  // helpers
  // lin one and two may be masked, so only the other five always count
  wire logic   hard_ok = buck_one_good & buck_two_good & buck_three_good &
    (lin_reg_three_good | load_switch_one) & (lin_reg_four_good | load_switch_two);
  wire logic   all_ok  = hard_ok & lin_reg_one_good & lin_reg_two_good;
  logic [31:0] ok_cnt;
  logic [31:0] all_cnt;

  // cycles the rails stayed good; wraps only after far longer than any run
  always_ff @(posedge core_clk) begin
    ok_cnt <= (!rst_b || !hard_ok) ? 32'h0 : ok_cnt + 32'h1;
    all_cnt <= (!rst_b || !all_ok) ? 32'h0 : all_cnt + 32'h1;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // ========================
  // checks
  a_reset_clears: assert property (disable iff (1'b0)
    !rst_b |=> !rails_good_pin && !buck_one_external_adjust && buck_one_voltage_code == 6'h00)
    else $error("reset left outputs set");
  a_buck_one_drop: assert property (
    !buck_one_good |-> ##[1:2] !rails_good_pin) else $error("pin high, buck one down");
  a_buck_three_drop: assert property (
    !buck_three_good |-> ##[1:2] !rails_good_pin) else $error("pin high, buck three down");
  a_lin_three_drop: assert property (
    !(lin_reg_three_good || load_switch_one) |-> ##[1:2] !rails_good_pin)
    else $error("pin high, lin three down");
  a_adjust_write_timing: assert property (
    $changed(buck_one_external_adjust) |-> !$past(scl_in)) else $error("adjust moved, scl high");
  a_code_write_timing: assert property (
    $changed(buck_one_voltage_code) |-> !$past(scl_in)) else $error("code moved, scl high");
  a_rise_after_delay: assert property (
    $rose(rails_good_pin) |-> ok_cnt >= DLY0_CYC) else $error("pin rose too early");
  a_rise_within_bound: assert property (
    all_cnt == DLY3_CYC + 32'h8 |-> rails_good_pin) else $error("pin late to rise");

  c_pin_rise: cover property ($rose(rails_good_pin));
  c_pin_fall: cover property ($fell(rails_good_pin));
  c_adjust_set: cover property ($rose(buck_one_external_adjust));
endmodule

bind pgr_regs pgr_regs_chk #(.DLY0_CYC(DLY0_CYC), .DLY3_CYC(DLY3_CYC)) u_chk (
  .core_clk, .rst_b, .scl_in, .lin_reg_one_good, .lin_reg_two_good, .lin_reg_three_good,
  .lin_reg_four_good, .load_switch_one, .load_switch_two, .buck_one_good, .buck_two_good,
  .buck_three_good, .rails_good_pin, .buck_one_external_adjust, .buck_one_voltage_code
);

//--- pgr_host.sv
module pgr_host (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // ========================
  // serial host model
  // clock driven high, data released: the pull-up holds an idle data line high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // four clocks a phase, above the one the slave needs
  task automatic ph(input logic c, input logic d);
    scl <= c;
    sda_low <= ~d;
    repeat (4) @(posedge core_clk);
  endtask

  // data falls with the clock high; also a repeated start
  task automatic start();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask

  // data rises with the clock high
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask

  // byte plus ninth bit; ones release the line so the slave can drive it
  task automatic xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, w[i]);
      ph(1'b1, w[i]);
      r[i] = sda;
      ph(1'b0, w[i]);
    end
  endtask
endmodule

//--- pgr_tb.sv
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("[ERR] %0t got %0h exp %0h", $time, g, e); \
    end \
  end

module tb
  import pgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] DLY [4] = '{32'h14, 32'h64, 32'hc8, 32'h190};
  localparam logic [7:0]  BAD [4] = '{8'h00, 8'h7c, 8'h7e, 8'hff};
  localparam logic [8:0]  DROP [3] = '{9'h1fa, 9'h15e, 9'h1ee};

  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [8:0] rail = 9'h000;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       sda_out;
  logic       pin;
  logic       ext;
  logic [5:0] code;
  wire logic  sda = ~sda_low & (sda_oe ? sda_out : 1'b1);
  int         miscompares = 0;
  int         comparisons = 0;

  // 200 MHz
  always #2.5 core_clk = ~core_clk;

  pgr_regs #(.DLY0_CYC(DLY[0]), .DLY1_CYC(DLY[1]), .DLY2_CYC(DLY[2]), .DLY3_CYC(DLY[3])) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .lin_reg_one_good(rail[1]), .lin_reg_two_good(rail[0]),
    .lin_reg_three_good(rail[5]), .lin_reg_four_good(rail[6]), .load_switch_one(rail[7]),
    .load_switch_two(rail[8]), .buck_one_good(rail[4]), .buck_two_good(rail[3]),
    .buck_three_good(rail[2]), .rails_good_pin(pin), .buck_one_external_adjust(ext),
    .buck_one_voltage_code(code)
  );
  pgr_host u_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // ========================
  // bus tasks
  // pointer then data; every byte must be acked, even a discarded one
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [8:0] a0, a1, a2;
    u_host.start();
    u_host.xfer({PGR_BUS_ADDR, 2'b01}, a0);
    u_host.xfer({p, 1'b1}, a1);
    u_host.xfer({d, 1'b1}, a2);
    u_host.stop();
    `CHK({a0[0], a1[0], a2[0]}, 3'b000)
  endtask

  // pointer, repeated start, one byte read closed by a nack
  task automatic rc(input logic [7:0] p, input logic [7:0] e);
    logic [8:0] a0, a1, a2, d;
    u_host.start();
    u_host.xfer({PGR_BUS_ADDR, 2'b01}, a0);
    u_host.xfer({p, 1'b1}, a1);
    u_host.start();
    u_host.xfer({PGR_BUS_ADDR, 2'b11}, a2);
    u_host.xfer(9'h1ff, d);
    u_host.stop();
    `CHK({a0[0], a1[0], a2[0], d[8:1]}, {3'b000, e})
  endtask

  // key first, then the single protected write it allows
  task automatic uw(input logic [7:0] p, input logic [7:0] d);
    wr(PGR_OFF_UNLOCK_KEY, PGR_UNLOCK_CODE);
    wr(p, d);
  endtask

  // rails three and four also read good when used as switches
  function automatic logic [7:0] exp_st(input logic [8:0] v);
    return {1'b0, v[5] | v[7], v[6] | v[8], v[4:0]};
  endfunction

  // all rails good, then count cycles until the pin rises
  task automatic rise(input logic [31:0] lim);
    logic [31:0] n;
    n = 32'h0;
    rail <= 9'h1ff;
    // look just after the edge so the pin flop has settled, then realign
    while (pin !== 1'b1 && n < 32'h800) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    `CHK(n, lim + 32'h2)
  endtask

  task automatic conclude();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ========================
  // tests
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    // reset values, reserved bits, an unmapped place
    rc(PGR_OFF_UNLOCK_KEY, 8'h00);
    rc(PGR_OFF_GOOD_STATUS, 8'h00);
    rc(PGR_OFF_GOOD_CONTROL, 8'h0c);
    rc(PGR_OFF_BUCK_ONE, 8'h00);
    rc(8'h40, 8'h00);
    // wrong keys and no key keep the protected registers
    for (int i = 0; i < 4; i++) begin
      wr(PGR_OFF_UNLOCK_KEY, BAD[i]);
      wr(PGR_OFF_BUCK_ONE, 8'h3f);
      rc(PGR_OFF_BUCK_ONE, 8'h00);
    end
    wr(PGR_OFF_GOOD_CONTROL, 8'h00);
    rc(PGR_OFF_GOOD_CONTROL, 8'h0c);
    // one write passes, the next is refused, the key clears
    uw(PGR_OFF_BUCK_ONE, 8'hff);
    wr(PGR_OFF_BUCK_ONE, 8'h05);
    rc(PGR_OFF_UNLOCK_KEY, 8'h00);
    rc(PGR_OFF_BUCK_ONE, 8'hbf);
    `CHK({ext, code}, 7'h7f)
    uw(PGR_OFF_BUCK_ONE, 8'h2a);
    `CHK({ext, code}, 7'h2a)
    // each rail alone; status ignores writes
    wr(PGR_OFF_GOOD_STATUS, 8'hff);
    for (int i = 0; i < 9; i++) begin
      rail <= 9'h001 << i;
      rc(PGR_OFF_GOOD_STATUS, exp_st(9'h001 << i));
    end
    // every delay choice, masks open; lin one down drops the pin
    for (int k = 0; k < 4; k++) begin
      rail <= 9'h000;
      uw(PGR_OFF_GOOD_CONTROL, 8'(k));
      rise(DLY[k]);
      rail <= 9'h1fd;
      repeat (4) @(posedge core_clk);
      `CHK(pin, 1'b0)
    end
    // lin one masked, lin two still holds the pin down
    rail <= 9'h000;
    uw(PGR_OFF_GOOD_CONTROL, 8'hf8);
    rc(PGR_OFF_GOOD_CONTROL, 8'h08);
    rise(DLY[0]);
    repeat (420) @(posedge core_clk);
    rail <= 9'h1fd;
    repeat (4) @(posedge core_clk);
    `CHK(pin, 1'b1)
    rail <= 9'h1fc;
    repeat (4) @(posedge core_clk);
    `CHK(pin, 1'b0)
    // lin two masked instead: lin one still counts, then hard rails drop the pin
    uw(PGR_OFF_GOOD_CONTROL, 8'h04);
    repeat (40) @(posedge core_clk);
    `CHK(pin, 1'b0)
    for (int i = 0; i < 3; i++) begin
      rail <= 9'h1fe;
      repeat (40) @(posedge core_clk);
      `CHK(pin, 1'b1)
      rail <= DROP[i];
      repeat (4) @(posedge core_clk);
      `CHK(pin, 1'b0)
    end
    conclude();
  end

  // cut a hang short, well past the expected run length
  initial begin
    repeat (50000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
endmodule
